// >>> src/cpu_throttle_idle_control.sv
// Top of the CPU throttle and idle power controller
`timescale 1ns/1ps
module cpu_throttle_idle_control (
    input  wire logic                               mclk_in,
    input  wire logic                               rstn_in,
    input  wire logic                               enable_wr_in,
    input  wire logic                               enable_wdata_in,
    input  wire logic                               ratio_wr_in,
    input  wire logic [throttle_pkg::RATIO_W-1:0]   ratio_wdata_in,
    input  wire logic                               recover_on_irq_in,
    input  wire logic                               resume_reduced_on_return_in,
    input  wire logic                               halt_core_select_in,
    input  wire logic                               clock_output_pin_cfg_n_in,
    input  wire logic                               irq_in,
    input  wire logic                               sleep_instr_in,
    input  wire logic                               return_from_irq_instr_in,
    input  wire logic                               wdt_event_in,
    output logic                                    cpu_throttle_enable_out,
    output logic [throttle_pkg::RATIO_W-1:0]        ratio_out,
    output logic                                    cpu_run_out,
    output logic                                    fetch_run_out,
    output logic                                    periph_instr_clk_out,
    output logic                                    sys_periph_run_out,
    output logic                                    osc_periph_run_out,
    output logic                                    clock_output_pin_out,
    output logic                                    idle_out,
    output logic                                    sleep_out,
    output logic                                    wdt_reset_out,
    output logic                                    wdt_wake_out
);
    import throttle_pkg::*;

    pmode_e           mode;
    pmode_e           next_mode;
    logic             en;
    logic             next_en;
    logic [RATIO_W-1:0] ratio;
    logic             slot;
    logic             restart;
    logic             in_idle;
    logic             in_sleep;
    logic             irq_recover;
    logic             resume_set;

    assign in_idle  = (mode == IDLE);
    assign in_sleep = (mode == SLEEP);
    // Interrupt recovery only applies when throttling is active
    assign irq_recover = irq_in && recover_on_irq_in && en;
    assign resume_set  = return_from_irq_instr_in
                         && resume_reduced_on_return_in;

    // Software write loses to hardware events in the same cycle
    always_comb begin
        next_en = en;
        if (enable_wr_in) next_en = enable_wdata_in;
        if (resume_set) next_en = 1'b1;
        if (irq_recover) next_en = 1'b0;
    end
    // Watchdog wake never touches the enable bit
    assign restart = (next_en && !en) || ratio_wr_in;

    always_comb begin
        next_mode = mode;
        unique case (mode)
            RUN: begin
                if (sleep_instr_in && !irq_in)
                    next_mode = halt_core_select_in ? IDLE : SLEEP;
            end
            IDLE: begin
                if (irq_in || wdt_event_in) next_mode = RUN;
            end
            SLEEP: begin
                if (irq_in || wdt_event_in) next_mode = RUN;
            end
            // Spare state code falls back to normal running
            default: next_mode = RUN;
        endcase
    end

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            mode  <= RUN;
            en    <= ENABLE_RESET;
            ratio <= RATIO_RESET;
        end else begin
            mode <= next_mode;
            en   <= next_en;
            if (ratio_wr_in) ratio <= ratio_wdata_in;
        end
    end

    throttle_counter u_counter (
        .mclk_in    (mclk_in),
        .rstn_in    (rstn_in),
        .restart_in (restart),
        .ratio_in   (ratio),
        .slot_out   (slot)
    );

    clock_gates u_gates (
        .mclk_in              (mclk_in),
        .rstn_in              (rstn_in),
        .idle_in              (in_idle),
        .sleep_in             (in_sleep),
        .clock_output_pin_cfg_n_in      (clock_output_pin_cfg_n_in),
        .sys_periph_run_out   (sys_periph_run_out),
        .osc_periph_run_out   (osc_periph_run_out),
        .clock_output_pin_out (clock_output_pin_out)
    );

    assign cpu_throttle_enable_out = en;
    assign ratio_out               = ratio;
    // Without recovery the ISR keeps the throttled slot rate
    assign cpu_run_out   = (mode == RUN) && (!en || slot);
    assign fetch_run_out = cpu_run_out;
    assign periph_instr_clk_out = !in_sleep;
    assign idle_out      = in_idle;
    assign sleep_out     = in_sleep;
    assign wdt_reset_out = wdt_event_in && !in_idle && !in_sleep;
    assign wdt_wake_out  = wdt_event_in && (in_idle || in_sleep);

    a_idle_wake_irq: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        in_idle && irq_in |=> mode == RUN)
        else $error("idle not left on interrupt");
    a_wdt_no_reset: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        in_idle |-> !wdt_reset_out)
        else $error("watchdog reset in idle");
    a_wdt_keeps_en: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        in_idle && wdt_event_in && !irq_in && !enable_wr_in && !resume_set
        |=> en == $past(en))
        else $error("watchdog wake changed enable");
    a_recover_clear: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        irq_recover |=> !en)
        else $error("enable not cleared on recovery");
    a_resume_set: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        resume_set && !irq_recover |=> en)
        else $error("enable not set on return");
    a_sleep_select: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        mode == RUN && sleep_instr_in && !irq_in
        |=> (halt_core_select_in ? in_idle : in_sleep))
        else $error("wrong low-power mode");
    a_idle_halts: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        in_idle |-> !cpu_run_out && sys_periph_run_out)
        else $error("idle gating wrong");
    a_sleep_gates: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        in_sleep |-> !sys_periph_run_out && !cpu_run_out)
        else $error("sleep gating wrong");
    a_throttle_gap: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        en && ratio == 3'h1 && !ratio_wr_in && mode == RUN && cpu_run_out
        ##1 en && !ratio_wr_in && mode == RUN |-> !cpu_run_out)
        else $error("throttle ran two cycles in a row");
    a_wdt_reset_run: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        mode == RUN && wdt_event_in |-> wdt_reset_out)
        else $error("watchdog reset missing while running");
    a_wdt_wake_idle: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        in_idle && wdt_event_in |=> mode == RUN)
        else $error("watchdog did not wake idle");
    a_no_recover_keep: assert property (@(posedge mclk_in)
        disable iff (!rstn_in)
        irq_in && !recover_on_irq_in && en && !enable_wr_in |=> en)
        else $error("enable lost without recovery");
    a_periph_running: assert property (@(posedge mclk_in)
        disable iff (!rstn_in)
        !in_sleep |-> periph_instr_clk_out && sys_periph_run_out)
        else $error("peripheral clocks stopped outside sleep");
    a_restart_slot: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        restart |=> slot)
        else $error("counter did not restart");
    a_full_speed: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        mode == RUN && !en |-> cpu_run_out)
        else $error("CPU stalled at full speed");
    a_ratio_write: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        ratio_wr_in |=> ratio == $past(ratio_wdata_in))
        else $error("ratio write lost");
    a_idle_recover: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        in_idle && irq_in && recover_on_irq_in && en
        |=> mode == RUN && !en)
        else $error("idle exit kept throttling");
    c_idle_entry: cover property (@(posedge mclk_in) mode == RUN ##1 in_idle);
    c_sleep_entry: cover property (@(posedge mclk_in) mode == RUN ##1 in_sleep);
    c_recover: cover property (@(posedge mclk_in) irq_recover);
    c_wdt_wake: cover property (@(posedge mclk_in) in_idle && wdt_event_in);
endmodule // cpu_throttle_idle_control

// >>> src/throttle_pkg.sv
// Package of constants for the CPU throttle and idle controller
package throttle_pkg;
    localparam int          RATIO_W      = 3;
    localparam int          CNT_W        = 8;
    localparam logic [2:0]  RATIO_RESET  = 3'h0;
    localparam logic        ENABLE_RESET = 1'b0;
    localparam logic        RECOVER_RESET = 1'b0;
    localparam logic        RESUME_RESET  = 1'b0;
    localparam logic        IDLE_RESET   = 1'b0;
    // Ratio code k gives a period of 2^(k+1) cycles: 001 -> 4, 100 -> 32
    localparam logic [2:0]  RATIO_MAX    = 3'h7;
    typedef enum logic [1:0] {RUN, IDLE, SLEEP} pmode_e;
endpackage

// >>> src/throttle_counter.sv
// Throttle period counter producing the CPU run slot
`timescale 1ns/1ps
module throttle_counter (
    input  wire logic                           mclk_in,
    input  wire logic                           rstn_in,
    input  wire logic                           restart_in,
    input  wire logic [throttle_pkg::RATIO_W-1:0] ratio_in,
    output logic                                slot_out
);
    import throttle_pkg::*;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] last;
    logic [CNT_W-1:0] next_cnt;
    assign last     = CNT_W'((9'h2 << ratio_in) - 9'h1);
    assign next_cnt = (restart_in || cnt >= last) ? '0 : cnt + 8'h1;
    assign slot_out = (cnt == '0);
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) cnt <= '0;
        else cnt <= next_cnt;
    end
endmodule // throttle_counter

// >>> src/clock_gates.sv
// Clock-enable outputs derived from the power mode
`timescale 1ns/1ps
module clock_gates (
    input  wire logic mclk_in,
    input  wire logic rstn_in,
    input  wire logic idle_in,
    input  wire logic sleep_in,
    input  wire logic clock_output_pin_cfg_n_in,
    output logic      sys_periph_run_out,
    output logic      osc_periph_run_out,
    output logic      clock_output_pin_out
);
    logic tog;
    // Oscillator-sourced peripherals never gated here
    assign osc_periph_run_out = 1'b1;
    assign sys_periph_run_out = !sleep_in;
    // Divided by two so the pin toggles visibly; active when config is 0
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) tog <= 1'b0;
        else if (!sleep_in) tog <= ~tog;
    end
    assign clock_output_pin_out = !clock_output_pin_cfg_n_in && tog;

    a_pin_idle_toggle: assert property (@(posedge mclk_in)
        disable iff (!rstn_in)
        idle_in && !clock_output_pin_cfg_n_in ##1 idle_in && !clock_output_pin_cfg_n_in
        |-> clock_output_pin_out != $past(clock_output_pin_out))
        else $error("clock output stalled in idle");
endmodule // clock_gates

// >>> test/cpu_core_model.sv
// Behavioural CPU core counting the cycles it executes
`timescale 1ns/1ps
module cpu_core_model (
    input  wire logic mclk_in,
    input  wire logic clear_in,
    input  wire logic run_in,
    input  wire logic fetch_in,
    output int        executed_out
);
    // Mid-cycle sample, so combinational enables have settled
    always @(negedge mclk_in) begin
        if (clear_in)
            executed_out <= 0;
        else
            executed_out <= executed_out + int'(run_in & fetch_in);
    end
endmodule // cpu_core_model

// >>> test/cpu_throttle_idle_control_tb.sv
// Self-checking bench for the CPU throttle and idle controller
`timescale 1ns/1ps
module cpu_throttle_idle_control_tb;
    import throttle_pkg::*;
    typedef struct {logic [2:0] code; int runs;} row_s;
    logic mclk_in = 0, rstn_in = 0, enable_wr_in = 0, enable_wdata_in = 0;
    logic ratio_wr_in = 0, recover_on_irq_in = 0, clock_output_pin_cfg_n_in = 0;
    logic resume_reduced_on_return_in = 0, halt_core_select_in = 0;
    logic irq_in = 0, sleep_instr_in = 0, return_from_irq_instr_in = 0;
    logic wdt_event_in = 0, clear = 1, ck;
    logic [RATIO_W-1:0] ratio_wdata_in = 3'h0, ratio_out;
    logic cpu_throttle_enable_out, cpu_run_out, fetch_run_out, idle_out;
    logic periph_instr_clk_out, sys_periph_run_out, osc_periph_run_out;
    logic clock_output_pin_out, sleep_out, wdt_reset_out, wdt_wake_out;
    int err_total = 0, checks = 0, cycles = 0, executed;
    // 64 observed cycles hold 64 / 2^(code+1) run slots
    row_s rows [5] = '{'{3'h0, 32}, '{3'h1, 16}, '{3'h2, 8}, '{3'h3, 4},
                       '{3'h4, 2}};
    cpu_throttle_idle_control cpu_throttle_idle_control_i (
        .mclk_in, .rstn_in, .enable_wr_in, .enable_wdata_in, .ratio_wr_in,
        .ratio_wdata_in, .recover_on_irq_in, .resume_reduced_on_return_in,
        .halt_core_select_in, .clock_output_pin_cfg_n_in, .irq_in, .sleep_instr_in,
        .return_from_irq_instr_in, .wdt_event_in, .cpu_throttle_enable_out,
        .ratio_out, .cpu_run_out, .fetch_run_out, .periph_instr_clk_out,
        .sys_periph_run_out, .osc_periph_run_out, .clock_output_pin_out,
        .idle_out, .sleep_out, .wdt_reset_out, .wdt_wake_out);
    cpu_core_model cpu_core_model_i (.mclk_in, .clear_in(clear),
        .run_in(cpu_run_out), .fetch_in(fetch_run_out),
        .executed_out(executed));
    always #12.5 mclk_in = ~mclk_in;
    always @(posedge mclk_in) begin
        cycles++;
        if (cycles == 4000) begin
            err_total++;
            give_verdict();
        end
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic step(input int n = 1);
        repeat (n) @(posedge mclk_in);
        #1;
    endtask
    task automatic set_enable(input logic v);
        enable_wr_in = 1;
        enable_wdata_in = v;
        step();
        enable_wr_in = 0;
    endtask
    task automatic give_verdict();
        if (err_total == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        step(20);
        rstn_in = 1;
        chk({cpu_throttle_enable_out, ratio_out}, {ENABLE_RESET, RATIO_RESET});
        chk({cpu_run_out, idle_out, sleep_out, osc_periph_run_out}, 4'h9);
        foreach (rows[i]) begin
            ratio_wdata_in = rows[i].code;
            ratio_wr_in = 1;
            step();
            ratio_wr_in = 0;
            set_enable(1'b1);
            clear = 0;
            step(64);
            chk(executed[7:0], rows[i].runs[7:0]);
            chk({periph_instr_clk_out, sys_periph_run_out}, 2'h3);
            clear = 1;
            set_enable(1'b0);
        end
        set_enable(1'b1);
        irq_in = 1;
        step();
        irq_in = 0;
        chk(cpu_throttle_enable_out, 1'b1);
        halt_core_select_in = 1;
        recover_on_irq_in = 1;
        sleep_instr_in = 1;
        step();
        sleep_instr_in = 0;
        chk({idle_out, cpu_run_out, fetch_run_out, sys_periph_run_out}, 4'h9);
        ck = clock_output_pin_out;
        step();
        chk(clock_output_pin_out, 8'(!ck));
        wdt_event_in = 1;
        #1 chk({wdt_wake_out, wdt_reset_out}, 2'h2);
        step();
        wdt_event_in = 0;
        chk({idle_out, cpu_throttle_enable_out}, 2'h1);
        sleep_instr_in = 1;
        step();
        sleep_instr_in = 0;
        irq_in = 1;
        step();
        irq_in = 0;
        chk({idle_out, cpu_throttle_enable_out, cpu_run_out}, 3'h1);
        resume_reduced_on_return_in = 1;
        return_from_irq_instr_in = 1;
        step();
        return_from_irq_instr_in = 0;
        chk(cpu_throttle_enable_out, 1'b1);
        halt_core_select_in = 0;
        sleep_instr_in = 1;
        irq_in = 1;
        step();
        irq_in = 0;
        chk({sleep_out, idle_out, cpu_throttle_enable_out}, 3'h0);
        step();
        sleep_instr_in = 0;
        chk({sleep_out, sys_periph_run_out, osc_periph_run_out,
             periph_instr_clk_out, cpu_run_out}, 5'h14);
        rstn_in = 0;
        #1 chk({sleep_out, cpu_throttle_enable_out, cpu_run_out}, 3'h1);
        step();
        rstn_in = 1;
        step();
        wdt_event_in = 1;
        #1 chk({wdt_reset_out, wdt_wake_out, idle_out}, 3'h4);
        step();
        wdt_event_in = 0;
        chk(idle_out, 1'b0);
        give_verdict();
    end
endmodule // cpu_throttle_idle_control_tb
